// ===== inc/mocfg_map.vh
`ifndef MOCFG_MAP_VH
`define MOCFG_MAP_VH
// register addresses on the 7-bit host port
`define MOCFG_ADDR_MODE_CFG 7'h13
`define MOCFG_ADDR_ONES_COUNT 7'h7E
// field positions inside operating_mode_config
`define MOCFG_BIT_HPF_BYPASS 0
`define MOCFG_BIT_LPF_BYPASS 1
`define MOCFG_BIT_PULSE_DIS 2
`define MOCFG_ADC_LSB 3
`define MOCFG_ADC_MSB 5
`define MOCFG_BIT_SOFT_RST 6
`define MOCFG_BIT_RESERVED 7
// reset value: only the pulse-output disable bit is set
`define MOCFG_RESET_VALUE 8'h04
// adc control encodings
`define MOCFG_ADC_NORMAL 3'h0
`define MOCFG_ADC_CUR_OFF 3'h1
`define MOCFG_ADC_VOLT_OFF 3'h2
`define MOCFG_ADC_SLEEP 3'h3
`define MOCFG_ADC_SWAP 3'h4
`define MOCFG_ADC_CUR_OFF_REDIR 3'h5
`define MOCFG_ADC_VOLT_OFF_REDIR 3'h6
`define MOCFG_ADC_POWER_DOWN 3'h7
// quiet time after a soft reset, in ns, and the clock period
`define MOCFG_SOFT_RST_QUIET_NS 18000
`define MOCFG_CLK_PERIOD_NS 10
`define MOCFG_SOFT_RST_QUIET_CYC ((`MOCFG_SOFT_RST_QUIET_NS + `MOCFG_CLK_PERIOD_NS - 1) / `MOCFG_CLK_PERIOD_NS)
`endif

// ===== verification/meter_operating_mode_config_tb_top.sv
`timescale 1ns/1ps
module meter_operating_mode_config_tb_top;
  localparam QC = 10;
  logic core_clk = 0, rst = 1, reg_wr = 0, reg_rd = 0, active_pulse_req = 0, reactive_pulse_req = 0;
  logic [6:0] reg_addr = 7'h00;
  logic [7:0] reg_wdata = 8'h00, ext_rdata = 8'h00, cfg = 8'h04, v, ones;
  wire [7:0] reg_rdata;
  wire reg_rvalid, active_power_pulse_out, reactive_power_pulse_out, chip_reset, soft_reset_busy;
  wire highpass_bypass, lowpass_bypass, cur_adc_on, volt_adc_on;
  wire cur_path_from_volt, volt_path_from_cur, sleep_mode, power_down;
  // expected adc decode per field value, in the order of the control compare
  wire [47:0] dec_tab = {6'h01, 6'h28, 6'h14, 6'h3C, 6'h32, 6'h20, 6'h10, 6'h30};
  int failures = 0, checked = 0, seed;
  mocfg_operating_mode_config #(.QUIET_CYC(QC)) u_dut (.*);
  initial forever #5 core_clk = ~core_clk;
  task automatic cmp(input string n, input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e) begin
      failures++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task chk_ctl;
    cmp("control", {cfg[0], cfg[1], dec_tab[cfg[5:3] * 6 +: 6]}, {highpass_bypass, lowpass_bypass,
      cur_adc_on, volt_adc_on, cur_path_from_volt, volt_path_from_cur, sleep_mode, power_down});
  endtask
  // random requests; each output is last cycle's request unless gated
  task pulses;
    logic [1:0] p, q;
    q = {active_pulse_req, reactive_pulse_req};
    repeat (8) begin
      @(posedge core_clk);
      p = 2'($urandom);
      {active_pulse_req, reactive_pulse_req} <= p;
      #1 cmp("pulse", {6'h00, q & {2{!cfg[2]}}}, {6'h00, active_power_pulse_out, reactive_power_pulse_out});
      q = p;
    end
  endtask
  // the model drops bit 6 and returns to defaults on a soft reset
  task wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge core_clk);
    {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
    @(posedge core_clk);
    reg_wr <= 0;
    if (a == 7'h13) cfg = d[6] ? 8'h04 : d;
  endtask
  task rd(input logic [6:0] a);
    @(posedge core_clk);
    {reg_rd, reg_addr} <= {1'b1, a};
    ext_rdata <= 8'($urandom);
    @(posedge core_clk);
    reg_rd <= 0;
    #1 cmp("rvalid", 8'h01, {7'h00, reg_rvalid});
    v = (a == 7'h13) ? cfg : (a == 7'h7E) ? ones : ext_rdata;
    cmp("rdata", v, reg_rdata);
    ones = 8'($countones(v));
  endtask
  task wrap_up;
    $display("checks %0d mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial begin
    seed = $urandom(32'h78ce05f5);
    repeat (6) @(posedge core_clk);
    rst <= 0;
    rd(7'h13);
    chk_ctl;
    pulses;
    $display("done defaults");
    for (int f = 0; f < 8; f++) begin
      wr(7'h13, {1'b0, 1'b0, f[2:0], 3'($urandom)});
      @(posedge core_clk) #1 chk_ctl;
      pulses;
      rd(7'h13);
      rd(7'h7E);
    end
    $display("done modes");
    wr(7'h14, 8'hFF);
    wr(7'h7E, 8'hFF);
    wr(7'h13, 8'h1B);
    rd(7'h13);
    rd(7'h21);
    rd(7'h7E);
    $display("done access");
    wr(7'h13, 8'h7F);
    #1 cmp("reset", 8'h03, {6'h00, chip_reset, soft_reset_busy});
    repeat (QC - 1) @(posedge core_clk);
    #1 cmp("busy", 8'h01, {7'h00, soft_reset_busy});
    @(posedge core_clk) #1 cmp("busy", 8'h00, {7'h00, soft_reset_busy});
    chk_ctl;
    rd(7'h13);
    $display("done soft reset");
    wr(7'h13, 8'h3B);
    @(posedge core_clk) rst <= 1;
    repeat (2) @(posedge core_clk);
    rst <= 0;
    cfg = 8'h04;
    #1 chk_ctl;
    rd(7'h13);
    $display("done hard reset");
    wrap_up;
  end
  // cuts a hang short well beyond the some 170 cycles the tests need
  initial begin
    #100000;
    failures++;
    wrap_up;
  end
endmodule // meter_operating_mode_config_tb_top

// ===== verification/mocfg_operating_mode_config_props.sv
`timescale 1ns/1ps
module mocfg_operating_mode_config_props #(
  parameter QUIET_CYC = 10
) (
  // clock, reset and host port
  input wire core_clk, rst, reg_wr, reg_rd, reg_rvalid,
  input wire [6:0] reg_addr,
  input wire [7:0] reg_wdata, reg_rdata,
  // pulse pins, reset request and datapath control
  input wire active_power_pulse_out, reactive_power_pulse_out, chip_reset, soft_reset_busy,
  input wire highpass_bypass, lowpass_bypass, cur_adc_on, volt_adc_on,
  input wire cur_path_from_volt, volt_path_from_cur, sleep_mode, power_down
);
  // adc decode per field value: adc on pair, path swaps, sleep, power-down
  wire [47:0] dec_tab = {6'h01, 6'h28, 6'h14, 6'h3C, 6'h32, 6'h20, 6'h10, 6'h30};
  wire [5:0] dec = {cur_adc_on, volt_adc_on, cur_path_from_volt, volt_path_from_cur,
    sleep_mode, power_down};
  wire cfg_wr = reg_wr && reg_addr == 7'h13;
  reg [15:0] busy_cyc;
  // counts busy cycles; a counter, since the window is too long to unroll
  always @(posedge core_clk)
    busy_cyc <= (rst || !soft_reset_busy) ? 16'h0000 : busy_cyc + 16'h0001;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  hpf_track_a:
    assert property (cfg_wr && !reg_wdata[6] |-> ##2 highpass_bypass == $past(reg_wdata[0], 2)) else $error("hpf bypass wrong");
  lpf_track_a:
    assert property (cfg_wr && !reg_wdata[6] |-> ##2 lowpass_bypass == $past(reg_wdata[1], 2)) else $error("lpf bypass wrong");
  pulse_off_a:
    assert property (chip_reset |=> !active_power_pulse_out && !reactive_power_pulse_out) else $error("pulse not gated");
  adc_decode_a:
    assert property (cfg_wr && !reg_wdata[6] |-> ##2 dec == dec_tab[$past(reg_wdata[5:3], 2) * 6 +: 6]) else $error("adc decode wrong");
  soft_rst_a:
    assert property (cfg_wr && reg_wdata[6] |=> chip_reset && soft_reset_busy ##1 dec == 6'h30 && !highpass_bypass) else $error("soft reset wrong");
  busy_len_a:
    assert property ($fell(soft_reset_busy) |-> busy_cyc == QUIET_CYC) else $error("quiet window length wrong");
  ones_count_a:
    assert property (reg_rd ##1 !reg_rd ##1 reg_rd && reg_addr == 7'h7E |=> reg_rdata == $countones($past(reg_rdata))) else $error("ones count wrong");
  rd_valid_a:
    assert property (reg_rd |=> reg_rvalid) else $error("read valid missing");
  readback_a:
    assert property (cfg_wr && !reg_wdata[6] ##1 !cfg_wr ##1 reg_rd && reg_addr == 7'h13 && !cfg_wr |=> reg_rdata == ($past(reg_wdata, 3) & 8'hBF)) else $error("readback wrong");
  cover property (chip_reset);
  cover property (power_down);
  cover property (reg_rd && reg_addr == 7'h7E);
endmodule // mocfg_operating_mode_config_props
bind mocfg_operating_mode_config mocfg_operating_mode_config_props #(.QUIET_CYC(QUIET_CYC)) u_props (.*);

// ===== verilog/mocfg_ones_count.v
`timescale 1ns/1ps
// counts the set bits of a word; combinational
module mocfg_ones_count #(
  parameter WIDTH = 8,
  parameter CW = 8
) (
  // word in
  input wire [WIDTH-1:0] word,
  // number of ones
  output reg [CW-1:0] count
);
  integer i;
  // simple adder chain, small enough for byte-wide data
  always @* begin
    count = {CW{1'b0}};
    for (i = 0; i < WIDTH; i = i + 1) begin
      count = count + {{(CW-1){1'b0}}, word[i]};
    end
  end
endmodule // mocfg_ones_count

// ===== verilog/mocfg_operating_mode_config.v
`timescale 1ns/1ps
`include "mocfg_map.vh"
module mocfg_operating_mode_config #(
  parameter QUIET_CYC = `MOCFG_SOFT_RST_QUIET_CYC
) (
  // clock and reset
  input wire core_clk,
  input wire rst,
  // register port from the serial interface
  input wire reg_wr,
  input wire reg_rd,
  input wire [6:0] reg_addr,
  input wire [7:0] reg_wdata,
  // value of registers outside this block, for reads at other addresses
  input wire [7:0] ext_rdata,
  output reg [7:0] reg_rdata,
  output reg reg_rvalid,
  // raw pulse requests from the frequency generators
  input wire active_pulse_req,
  input wire reactive_pulse_req,
  // pulse pins
  output reg active_power_pulse_out,
  output reg reactive_power_pulse_out,
  // datapath control
  output reg highpass_bypass,
  output reg lowpass_bypass,
  output reg cur_adc_on,
  output reg volt_adc_on,
  output reg cur_path_from_volt,
  output reg volt_path_from_cur,
  output reg sleep_mode,
  output reg power_down,
  // chip-wide reset request and quiet window
  output reg chip_reset,
  output reg soft_reset_busy
);
  reg [7:0] operating_mode_config;
  reg [7:0] read_ones_count;
  reg [15:0] quiet_cnt;
  wire [7:0] rd_value;
  wire [7:0] rd_ones;
  wire [2:0] adc_control_field;
  wire soft_chip_reset;
  wire wr_cfg;

  assign adc_control_field = operating_mode_config[`MOCFG_ADC_MSB:`MOCFG_ADC_LSB];
  assign wr_cfg = reg_wr && (reg_addr == `MOCFG_ADDR_MODE_CFG);
  assign soft_chip_reset = wr_cfg && reg_wdata[`MOCFG_BIT_SOFT_RST];

  // read mux: own registers first, else the outside value
  assign rd_value = (reg_addr == `MOCFG_ADDR_MODE_CFG) ? operating_mode_config :
                    (reg_addr == `MOCFG_ADDR_ONES_COUNT) ? read_ones_count : ext_rdata;

  mocfg_ones_count #(
    .WIDTH(8),
    .CW(8)
  ) u_ones (
    .word(rd_value),
    .count(rd_ones)
  );

  // configuration register; soft reset bit is self-clearing so it never reads 1
  always @(posedge core_clk) begin
    if (rst || soft_chip_reset) begin
      operating_mode_config <= `MOCFG_RESET_VALUE;
    end else if (wr_cfg) begin
      operating_mode_config <= reg_wdata & ~(8'h01 << `MOCFG_BIT_SOFT_RST);
    end
  end

  // read data and ones count; count reflects the value just returned
  always @(posedge core_clk) begin
    if (rst) begin
      reg_rdata <= 8'h00;
      reg_rvalid <= 1'b0;
      read_ones_count <= 8'h00;
    end else begin
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        reg_rdata <= rd_value;
        read_ones_count <= rd_ones;
      end
    end
  end

  // soft reset pulse and quiet window; the window only flags, the host must honour it
  always @(posedge core_clk) begin
    if (rst) begin
      chip_reset <= 1'b0;
      quiet_cnt <= 16'h0000;
      soft_reset_busy <= 1'b0;
    end else begin
      chip_reset <= soft_chip_reset;
      if (soft_chip_reset) begin
        quiet_cnt <= QUIET_CYC[15:0];
        soft_reset_busy <= 1'b1;
      end else if (quiet_cnt != 16'h0000) begin
        quiet_cnt <= quiet_cnt - 16'h0001;
        soft_reset_busy <= (quiet_cnt != 16'h0001);
      end else begin
        soft_reset_busy <= 1'b0;
      end
    end
  end

  // filter and pulse gating, registered so outputs come from flops
  always @(posedge core_clk) begin
    if (rst) begin
      highpass_bypass <= 1'b0;
      lowpass_bypass <= 1'b0;
      active_power_pulse_out <= 1'b0;
      reactive_power_pulse_out <= 1'b0;
    end else begin
      highpass_bypass <= operating_mode_config[`MOCFG_BIT_HPF_BYPASS];
      lowpass_bypass <= operating_mode_config[`MOCFG_BIT_LPF_BYPASS];
      active_power_pulse_out <= active_pulse_req &
                                ~operating_mode_config[`MOCFG_BIT_PULSE_DIS];
      reactive_power_pulse_out <= reactive_pulse_req &
                                  ~operating_mode_config[`MOCFG_BIT_PULSE_DIS];
    end
  end

  // adc control decode; power-down also stops both converter groups, sleep leaves them on
  always @(posedge core_clk) begin
    if (rst) begin
      cur_adc_on <= 1'b1;
      volt_adc_on <= 1'b1;
      cur_path_from_volt <= 1'b0;
      volt_path_from_cur <= 1'b0;
      sleep_mode <= 1'b0;
      power_down <= 1'b0;
    end else begin
      cur_adc_on <= 1'b1;
      volt_adc_on <= 1'b1;
      cur_path_from_volt <= 1'b0;
      volt_path_from_cur <= 1'b0;
      sleep_mode <= 1'b0;
      power_down <= 1'b0;
      case (adc_control_field)
        `MOCFG_ADC_NORMAL: begin
          cur_adc_on <= 1'b1;
        end
        `MOCFG_ADC_SWAP: begin
          cur_path_from_volt <= 1'b1;
          volt_path_from_cur <= 1'b1;
        end
        `MOCFG_ADC_CUR_OFF: begin
          cur_adc_on <= 1'b0;
        end
        `MOCFG_ADC_VOLT_OFF: begin
          volt_adc_on <= 1'b0;
        end
        `MOCFG_ADC_CUR_OFF_REDIR: begin
          cur_adc_on <= 1'b0;
          volt_path_from_cur <= 1'b1;
        end
        `MOCFG_ADC_VOLT_OFF_REDIR: begin
          volt_adc_on <= 1'b0;
          cur_path_from_volt <= 1'b1;
        end
        `MOCFG_ADC_SLEEP: begin
          sleep_mode <= 1'b1;
        end
        `MOCFG_ADC_POWER_DOWN: begin
          power_down <= 1'b1;
          cur_adc_on <= 1'b0;
          volt_adc_on <= 1'b0;
        end
        default: begin
          cur_adc_on <= 1'b1;
        end
      endcase
    end
  end
endmodule // mocfg_operating_mode_config
